// *** rfmsc_pkg.sv ***
package rfmsc_pkg;
    // register byte addresses (one aligned word each)
    localparam logic [7:0] RADIO_CONTROL_ADDR  = 8'h00; // violation threshold, mode, flag
    localparam logic [7:0] MODEM_CONFIG_ADDR   = 8'h04; // line format select
    localparam logic [7:0] RADIO_MAIN_ADDR     = 8'h08; // synth word select, transmit enable
    localparam logic [7:0] TUNING_A_ADDR       = 8'h0C; // word A, high:mid:low bytes
    localparam logic [7:0] TUNING_B_ADDR       = 8'h10; // word B, high:mid:low bytes
    localparam logic [7:0] FSK_SEP_ADDR        = 8'h14; // separation word, 11 bits
    localparam logic [7:0] PLL_CTRL_ADDR       = 8'h18; // divider, alarm disable, alarms
    localparam logic [7:0] RADIO_DATA_ADDR     = 8'h1C; // radio data buffer
    localparam logic [7:0] SYNTH_RATIO_ADDR    = 8'h20; // numerator of synth ratio, read only
    localparam logic [7:0] STATUS_ADDR         = 8'h24; // active format, lock, byte strobe
    // field positions
    localparam int THRESH_LSB   = 1;
    localparam int VIOL_BIT     = 4;
    localparam int BYTEMODE_BIT = 0;
    localparam int ALDIS_BIT    = 2;
    localparam int ALH_BIT      = 1;
    localparam int ALL_BIT      = 0;
    localparam int REFERENCE_DIVIDER_LSB   = 3;
    // reset values
    localparam logic [2:0]  THRESH_RST  = 3'h3;
    localparam logic [23:0] TUNE_A_RST  = 24'h75A0CB;
    localparam logic [23:0] TUNE_B_RST  = 24'h75A54E;
    localparam logic [10:0] FSK_SEPARATION_WORD_RST    = 11'h059;
    localparam logic [4:0]  REFERENCE_DIVIDER_RST  = 5'h02;
    localparam logic [1:0]  FMT_RST     = 2'h0;
    // line formats and ratio terms
    localparam logic [1:0]  FMT_NRZ     = 2'h0;
    localparam logic [1:0]  FMT_MANCH   = 2'h1;
    localparam logic [25:0] RATIO_OFFS  = 26'h0002000; // 8192
    localparam int          RATIO_SHIFT = 14;          // divide by 16384
    localparam logic [3:0]  SAMPLES     = 4'hE;        // samples per symbol
    localparam logic [3:0]  BITS_BYTE   = 4'h8;
endpackage : rfmsc_pkg

// *** rfmsc_core.sv ***
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// What this block does
// - bitmode flag follows violation of current bit
// - bytemode flag ORs violations across byte
// - violation decided by programmable threshold field
// - correct samples of 14 versus limit; zero disables
// - flag valid only with Manchester format 01
// - buffer still loads best-guess data on violation
// - line format buffered, applies from next byte
// - format change spares byte in shift register
// - receive format applies at next radio irq
// - sync in NRZ, Manchester after sync irq
// - two tuning words, select bit chooses one
// - 24-bit words, each in one word register
// - 11-bit separation word sets FSK gap
// - ratio is word plus sep*txbit plus 8192
// - high-side injection inverts received data
// - alarms update only while alarm disable clear
module rfmsc_core (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        rxBitValid,
    input  wire logic        rxBitIn,
    input  wire logic [3:0]  rxGoodSamples,
    input  wire logic        rxSyncFound,
    input  wire logic        highSideLo,
    input  wire logic        tuneHighPin,
    input  wire logic        tuneLowPin,
    input  wire logic        lockPin,
    input  wire logic        txBitTick,
    output logic             txBitOut,
    output logic      [1:0]  activeFormat,
    output logic      [25:0] synthRatioNum,
    output logic      [4:0]  referenceDivider,
    output logic             radioIrqFlag
);
    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0]  violationThreshold; // bad samples allowed out of 14
        logic        byteMode;           // 1 byte transfer, 0 bit transfer
        logic        violationFlag;      // shown to software
        logic [1:0]  formatBuf;          // written format, waiting
        logic [1:0]  formatAct;          // format in force
        logic        synthSelect;        // 0 word A, 1 word B
        logic        txEnable;           // transmit when set
        logic [23:0] tuneA;              // word A
        logic [23:0] tuneB;              // word B
        logic [10:0] fskSep;             // separation word
        logic [4:0]  reference_divider;             // reference divider
        logic        alarmDisable;       // blocks alarm updates
        logic        alarmHigh;          // tuning too near supply
        logic        alarmLow;           // tuning too near ground
        logic [7:0]  radioData;          // radio data buffer
        logic [7:0]  shiftReg;           // byte on the line
        logic [3:0]  bitCount;           // bits shifted so far
        logic        byteViol;           // violation seen in this byte
        logic        txPending;          // buffer holds unsent byte
        logic        irq;                // radio irq flag
        logic        lockSync;           // synchronised lock
        logic [1:0]  tuneSync;           // synchronised alarm pins
        logic        apValid;            // data phase pending
        logic        apWrite;            // pending is a write
        logic [7:0]  apAddr;             // pending address
        logic [31:0] rdata;              // read data register
        logic        txBit;              // current transmit bit
    } rfmsc_state_s;

    rfmsc_state_s cur;       // registered state
    rfmsc_state_s next_cur;  // next state
    logic [2:0]   meta;      // first stages of pin synchronisers
    logic         symViol;   // current symbol violates coding
    logic         rxBit;     // received bit after injection fix
    logic         loadByte;  // shift register takes a new byte
    logic [23:0]  tuneSel;   // selected tuning word
    logic [31:0]  wd;        // write data for pending write

    ////////////////////////////////////////////////////////////////////////////////
    // first synchroniser stage, read only by the second
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            meta <= 3'h0;
        end else begin
            meta <= {lockPin, tuneHighPin, tuneLowPin};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // symbol judgement and derived values
    always_comb begin
        // a zero limit turns detection off
        symViol  = (cur.violationThreshold != 3'h0)
                 && (rxGoodSamples < rfmsc_pkg::SAMPLES - {1'b0, cur.violationThreshold});
        rxBit    = rxBitIn ^ highSideLo;
        tuneSel  = cur.synthSelect ? cur.tuneB : cur.tuneA;
        wd       = hwdata;
        loadByte = cur.txEnable ? (txBitTick && (cur.bitCount == 4'h0) && cur.txPending)
                                : (rxBitValid && (!cur.byteMode
                                   || cur.bitCount == rfmsc_pkg::BITS_BYTE - 4'h1));
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic for bus, datapath and status
    always_comb begin
        next_cur          = cur;
        next_cur.lockSync = meta[2];
        next_cur.tuneSync = meta[1:0];
        next_cur.irq      = 1'b0;
        // alarms refresh only while enabled
        if (!cur.alarmDisable) begin
            next_cur.alarmHigh = cur.tuneSync[1];
            next_cur.alarmLow  = cur.tuneSync[0];
        end
        // receive path
        if (!cur.txEnable && rxBitValid) begin
            if (cur.byteMode) begin
                next_cur.shiftReg = {cur.shiftReg[6:0], rxBit};
                next_cur.byteViol = cur.byteViol | symViol;
                next_cur.bitCount = cur.bitCount + 4'h1;
                if (loadByte) begin
                    // best guess still lands in the buffer
                    next_cur.radioData = {cur.shiftReg[6:0], rxBit};
                    // any bad bit of the byte
                    next_cur.violationFlag = (cur.byteViol | symViol)
                                           && (cur.formatAct == rfmsc_pkg::FMT_MANCH);
                    next_cur.byteViol = 1'b0;
                    next_cur.bitCount = 4'h0;
                end
            end else begin
                next_cur.radioData = {7'h00, rxBit};
                // flag tracks bit 0 of the buffer
                next_cur.violationFlag = symViol && (cur.formatAct == rfmsc_pkg::FMT_MANCH);
            end
        end
        // sync byte found also ends a byte
        if (!cur.txEnable && rxSyncFound) begin
            next_cur.bitCount = 4'h0;
            next_cur.byteViol = 1'b0;
        end
        // transmit path; the byte in flight keeps its own format
        if (cur.txEnable && txBitTick) begin
            if (loadByte) begin
                next_cur.shiftReg  = cur.radioData;
                next_cur.txPending = 1'b0;
                next_cur.bitCount  = 4'h1;
                next_cur.txBit     = cur.radioData[7];
            end else if (cur.bitCount != 4'h0) begin
                next_cur.shiftReg = {cur.shiftReg[6:0], 1'b0};
                next_cur.txBit    = cur.shiftReg[6];
                next_cur.bitCount = (cur.bitCount == rfmsc_pkg::BITS_BYTE - 4'h1)
                                  ? 4'h0 : cur.bitCount + 4'h1;
            end
        end
        // irq and format copy at shift register load
        if (loadByte || (!cur.txEnable && rxSyncFound)) begin
            next_cur.irq       = 1'b1;
            next_cur.formatAct = cur.formatBuf;
        end
        // bus data phase
        next_cur.apValid = 1'b0;
        if (cur.apValid && cur.apWrite) begin
            unique case (cur.apAddr)
                rfmsc_pkg::RADIO_CONTROL_ADDR: begin
                    next_cur.violationThreshold = wd[rfmsc_pkg::THRESH_LSB +: 3];
                    next_cur.byteMode           = wd[rfmsc_pkg::BYTEMODE_BIT];
                end
                rfmsc_pkg::MODEM_CONFIG_ADDR: next_cur.formatBuf = wd[1:0];
                rfmsc_pkg::RADIO_MAIN_ADDR: begin
                    next_cur.synthSelect = wd[0];
                    next_cur.txEnable    = wd[1];
                end
                rfmsc_pkg::TUNING_A_ADDR: next_cur.tuneA = wd[23:0];
                rfmsc_pkg::TUNING_B_ADDR: next_cur.tuneB = wd[23:0];
                rfmsc_pkg::FSK_SEP_ADDR:  next_cur.fskSep = wd[10:0];
                rfmsc_pkg::PLL_CTRL_ADDR: begin
                    next_cur.reference_divider       = wd[rfmsc_pkg::REFERENCE_DIVIDER_LSB +: 5];
                    next_cur.alarmDisable = wd[rfmsc_pkg::ALDIS_BIT];
                end
                rfmsc_pkg::RADIO_DATA_ADDR: begin
                    next_cur.radioData = wd[7:0];
                    next_cur.txPending = 1'b1;
                end
                default: begin
                    // unmapped or read-only: write ignored
                end
            endcase
        end
        // address phase capture
        if (hsel && hready && htrans[1]) begin
            next_cur.apValid = 1'b1;
            next_cur.apWrite = hwrite;
            next_cur.apAddr  = haddr[7:0];
            if (!hwrite) begin
                unique case (haddr[7:0])
                    rfmsc_pkg::RADIO_CONTROL_ADDR:
                        next_cur.rdata = {27'h0, cur.violationFlag,
                                          cur.violationThreshold, cur.byteMode};
                    rfmsc_pkg::MODEM_CONFIG_ADDR: next_cur.rdata = {30'h0, cur.formatBuf};
                    rfmsc_pkg::RADIO_MAIN_ADDR:
                        next_cur.rdata = {30'h0, cur.txEnable, cur.synthSelect};
                    rfmsc_pkg::TUNING_A_ADDR: next_cur.rdata = {8'h00, cur.tuneA};
                    rfmsc_pkg::TUNING_B_ADDR: next_cur.rdata = {8'h00, cur.tuneB};
                    rfmsc_pkg::FSK_SEP_ADDR:  next_cur.rdata = {21'h0, cur.fskSep};
                    rfmsc_pkg::PLL_CTRL_ADDR:
                        next_cur.rdata = {24'h0, cur.reference_divider, cur.alarmDisable,
                                          cur.alarmHigh, cur.alarmLow};
                    rfmsc_pkg::RADIO_DATA_ADDR: next_cur.rdata = {24'h0, cur.radioData};
                    rfmsc_pkg::SYNTH_RATIO_ADDR: next_cur.rdata = {6'h00, synthRatioNum};
                    rfmsc_pkg::STATUS_ADDR:
                        next_cur.rdata = {28'h0, cur.lockSync, cur.irq, cur.formatAct};
                    default: next_cur.rdata = 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cur                    <= '0;
            cur.violationThreshold <= rfmsc_pkg::THRESH_RST;
            cur.formatBuf          <= rfmsc_pkg::FMT_RST;
            cur.formatAct          <= rfmsc_pkg::FMT_RST;
            cur.tuneA              <= rfmsc_pkg::TUNE_A_RST;
            cur.tuneB              <= rfmsc_pkg::TUNE_B_RST;
            cur.fskSep             <= rfmsc_pkg::FSK_SEPARATION_WORD_RST;
            cur.reference_divider             <= rfmsc_pkg::REFERENCE_DIVIDER_RST;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        hrdata           = cur.rdata;
        hreadyout        = 1'b1;
        hresp            = 1'b0;
        txBitOut         = cur.txBit;
        activeFormat     = cur.formatAct;
        referenceDivider = cur.reference_divider;
        radioIrqFlag     = cur.irq;
        // numerator over 16384; transmit bit zero in receive
        synthRatioNum    = {2'h0, tuneSel}
                         + ((cur.txEnable && cur.txBit) ? {15'h0, cur.fskSep} : 26'h0)
                         + rfmsc_pkg::RATIO_OFFS;
    end
endmodule : rfmsc_core

// *** rfmsc_core_checker.sv ***
`timescale 1ns/1ps
// watches the block's ports for bus, format and transmit timing
module rfmsc_core_checker (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        rxBitValid,
    input wire logic        rxSyncFound,
    input wire logic        txBitTick,
    input wire logic        txBitOut,
    input wire logic [1:0]  activeFormat,
    input wire logic [4:0]  referenceDivider,
    input wire logic        radioIrqFlag
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    logic rdTake; // read address phase taken last edge
    logic pllWr;  // write address phase to the pll word taken last edge
    ////////////////////////////////////////////////////////////////////////
    // remember which address phases were accepted
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdTake <= 1'b0;
            pllWr  <= 1'b0;
        end else begin
            rdTake <= hsel && hready && htrans[1] && !hwrite;
            pllWr  <= hsel && hready && htrans[1] && hwrite
                      && (haddr == 32'(rfmsc_pkg::PLL_CTRL_ADDR));
        end
    end
    ////////////////////////////////////////////////////////////////////////
    ready_always_a: assert property (hreadyout) else $error("wait state inserted");
    resp_okay_a: assert property (!hresp) else $error("error response seen");
    rdata_hold_a: assert property ($changed(hrdata) |-> rdTake || $past(rdTake))
        else $error("read data moved without a read");
    divider_write_a: assert property ($changed(referenceDivider) |-> pllWr || $past(pllWr))
        else $error("divider moved without a write");
    irq_pulse_a: assert property (radioIrqFlag |=> !radioIrqFlag)
        else $error("irq longer than one cycle");
    irq_cause_a: assert property ($rose(radioIrqFlag) |-> $past(rxBitValid) ||
        $past(rxBitValid, 2) || $past(txBitTick) || $past(rxSyncFound) || $past(rxSyncFound, 2))
        else $error("irq without a bit, tick or sync");
    format_on_irq_a: assert property ($changed(activeFormat) |->
        ($past(radioIrqFlag) || $past(radioIrqFlag, 2)) or (##[0:2] radioIrqFlag))
        else $error("format changed away from a byte boundary");
    txbit_on_tick_a: assert property ($changed(txBitOut) |-> $past(txBitTick))
        else $error("transmit bit moved without a tick");
    cover property (radioIrqFlag);
    cover property ($changed(activeFormat));
    cover property ($rose(txBitOut));
endmodule : rfmsc_core_checker

bind rfmsc_core rfmsc_core_checker rfmsc_core_checker_inst (
    .clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .rxBitValid(rxBitValid), .rxSyncFound(rxSyncFound),
    .txBitTick(txBitTick), .txBitOut(txBitOut), .activeFormat(activeFormat),
    .referenceDivider(referenceDivider), .radioIrqFlag(radioIrqFlag));

// *** rfmsc_radio_model.sv ***
`timescale 1ns/1ps
// far radio: hands over received bits and paces transmit bits
module rfmsc_radio_model (
    input  wire logic       clock,
    output logic            rxBitValid,
    output logic            rxBitIn,
    output logic      [3:0] rxGoodSamples,
    output logic            rxSyncFound,
    output logic            txBitTick
);
    logic [2:0] tickCnt; // bit period divider
    initial begin
        {rxBitValid, rxBitIn, rxGoodSamples, rxSyncFound, txBitTick, tickCnt} = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one transmit bit period every eight cycles
    always @(posedge clock) begin
        tickCnt   <= tickCnt + 3'h1;
        txBitTick <= (tickCnt == 3'h7);
    end
    // one bit; afterwards lines carry the inverse so stale data never looks valid
    task automatic send_bit(input logic b, input logic [3:0] g);
        @(posedge clock);
        {rxBitValid, rxBitIn, rxGoodSamples} <= {1'b1, b, g};
        @(posedge clock);
        {rxBitValid, rxBitIn, rxGoodSamples} <= {1'b0, ~b, ~g};
        repeat (2) @(posedge clock);
    endtask : send_bit
    // sync byte found: one-cycle pulse on rxSyncFound that ends a byte
    task automatic sync_pulse();
        @(posedge clock);
        rxSyncFound <= 1'b1;
        @(posedge clock);
        rxSyncFound <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : sync_pulse
endmodule : rfmsc_radio_model

// *** testbench.sv ***
`timescale 1ns/1ps
// register-level bench for the modem format and synth control block
module testbench;
    logic        clock, nrst, hsel, hwrite, hreadyout, hresp, highSideLo;
    logic        tuneHighPin, tuneLowPin, lockPin, rxBitValid, rxBitIn, rxSyncFound;
    logic        txBitTick, txBitOut, radioIrqFlag;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, activeFormat;
    logic [2:0]  hsize;
    logic [3:0]  rxGoodSamples;
    logic [4:0]  referenceDivider;
    logic [25:0] synthRatioNum;
    logic [7:0]  bytes [3] = '{8'hC3, 8'h5A, 8'h3C}; // receive bytes
    int          lims [5] = '{3, 3, 3, 0, 7};         // bit-mode violation limits
    int          goods [5] = '{14, 10, 11, 0, 6};     // bit-mode good sample counts
    int          num_errors, samples_checked, i, k;
    rfmsc_core rfmsc_core_inst (.clock(clock), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxBitValid(rxBitValid),
        .rxBitIn(rxBitIn), .rxGoodSamples(rxGoodSamples), .rxSyncFound(rxSyncFound),
        .highSideLo(highSideLo), .tuneHighPin(tuneHighPin), .tuneLowPin(tuneLowPin),
        .lockPin(lockPin), .txBitTick(txBitTick), .txBitOut(txBitOut),
        .activeFormat(activeFormat), .synthRatioNum(synthRatioNum),
        .referenceDivider(referenceDivider), .radioIrqFlag(radioIrqFlag));
    rfmsc_radio_model rfmsc_radio_model_inst (.clock(clock), .rxBitValid(rxBitValid),
        .rxBitIn(rxBitIn), .rxGoodSamples(rxGoodSamples), .rxSyncFound(rxSyncFound),
        .txBitTick(txBitTick));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic final_report();
        if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // one AHB-Lite single transfer; read data kept in rd
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        {hsel, hwrite, haddr, htrans} <= {1'b1, w, 32'(a), 2'h2};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        num_errors++;
        final_report();
    end
    // main sequence
    initial begin
        {hsel, hwrite, highSideLo, tuneHighPin, tuneLowPin, lockPin} = '0;
        {haddr, hwdata, htrans, hsize, nrst, num_errors, samples_checked} = '0;
        hsize = 3'h2;
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        lockPin <= 1'b1;
        @(posedge clock);
        check(32'(synthRatioNum), 32'(rfmsc_pkg::TUNE_A_RST) + 32'h2000);
        rdchk(rfmsc_pkg::TUNING_A_ADDR, 32'(rfmsc_pkg::TUNE_A_RST));
        rdchk(rfmsc_pkg::TUNING_B_ADDR, 32'(rfmsc_pkg::TUNE_B_RST));
        rdchk(rfmsc_pkg::FSK_SEP_ADDR, 32'(rfmsc_pkg::FSK_SEPARATION_WORD_RST));
        rdchk(rfmsc_pkg::RADIO_CONTROL_ADDR, 32'h6);
        rdchk(8'h40, 32'h0);
        wr(rfmsc_pkg::RADIO_MAIN_ADDR, 32'h1);
        rdchk(rfmsc_pkg::SYNTH_RATIO_ADDR, 32'(rfmsc_pkg::TUNE_B_RST) + 32'h2000);
        rdchk(rfmsc_pkg::STATUS_ADDR, 32'h8);
        check(32'(synthRatioNum), 32'(rfmsc_pkg::TUNE_B_RST) + 32'h2000);
        // receive format waits for the sync interrupt
        wr(rfmsc_pkg::MODEM_CONFIG_ADDR, 32'(rfmsc_pkg::FMT_MANCH));
        check(32'(activeFormat), 32'(rfmsc_pkg::FMT_NRZ));
        rfmsc_radio_model_inst.sync_pulse();
        check(32'(activeFormat), 32'(rfmsc_pkg::FMT_MANCH));
        // bit mode: limit, good samples, bit; flag when limit is nonzero and good < 14 - limit
        for (i = 0; i < 5; i++) begin
            k = lims[i];
            wr(rfmsc_pkg::RADIO_CONTROL_ADDR, 32'(k << 1));
            rfmsc_radio_model_inst.send_bit(1'(i), 4'(goods[i]));
            rdchk(rfmsc_pkg::RADIO_DATA_ADDR, 32'(i % 2));
            rdchk(rfmsc_pkg::RADIO_CONTROL_ADDR,
                  32'(k << 1) | ((i % 3 == 1) ? 32'h10 : 32'h0));
        end
        highSideLo <= 1'b1;
        rfmsc_radio_model_inst.send_bit(1'b1, 4'hE);
        rdchk(rfmsc_pkg::RADIO_DATA_ADDR, 32'h0);
        highSideLo <= 1'b0;
        // byte mode, limit 3: one bad bit per byte, format switch before the second byte, then NRZ
        // violations here are sent on purpose; other systems ignore the flag
        wr(rfmsc_pkg::RADIO_CONTROL_ADDR, 32'h7);
        for (k = 0; k < 3; k++) begin
            if (k == 1) wr(rfmsc_pkg::MODEM_CONFIG_ADDR, 32'(rfmsc_pkg::FMT_NRZ));
            for (i = 7; i >= 0; i--) begin
                if (k == 1 && i == 3) begin
                    check(32'(activeFormat), 32'(rfmsc_pkg::FMT_MANCH));
                end
                rfmsc_radio_model_inst.send_bit(bytes[k][i], (i == 3) ? 4'h2 : 4'hE);
            end
            rdchk(rfmsc_pkg::RADIO_DATA_ADDR, 32'(bytes[k]));
            // byte in flight keeps Manchester; NRZ only from the third byte
            rdchk(rfmsc_pkg::RADIO_CONTROL_ADDR, (k == 2) ? 32'h7 : 32'h17);
        end
        check(32'(activeFormat), 32'(rfmsc_pkg::FMT_NRZ));
        // tuning alarms follow pins, then hold once disabled
        tuneHighPin <= 1'b1;
        repeat (4) @(posedge clock);
        rdchk(rfmsc_pkg::PLL_CTRL_ADDR, 32'h12);
        wr(rfmsc_pkg::PLL_CTRL_ADDR, 32'hC4);
        {tuneHighPin, tuneLowPin} <= 2'b01;
        repeat (4) @(posedge clock);
        rdchk(rfmsc_pkg::PLL_CTRL_ADDR, 32'hC6);
        check(32'(referenceDivider), 32'd24);
        // transmit A5 with word B; format written mid-byte waits for the next byte
        wr(rfmsc_pkg::MODEM_CONFIG_ADDR, 32'(rfmsc_pkg::FMT_MANCH));
        wr(rfmsc_pkg::RADIO_DATA_ADDR, 32'hA5);
        wr(rfmsc_pkg::RADIO_MAIN_ADDR, 32'h3);
        for (i = 0; i < 9; i++) begin
            @(posedge clock iff txBitTick);
            #1;
            // expected bit: A5 MSB first, then bit 7 of 0F
            k = (i == 8) ? 0 : ((8'hA5 >> (7 - i)) & 8'h1);
            check(32'(txBitOut), 32'(k));
            check(32'(synthRatioNum), 32'(rfmsc_pkg::TUNE_B_RST) + 32'h2000 +
                ((k != 0) ? 32'(rfmsc_pkg::FSK_SEPARATION_WORD_RST) : 32'h0));
            check(32'(activeFormat), (i == 8) ? 32'h0 : 32'h1);
            if (i == 1) wr(rfmsc_pkg::MODEM_CONFIG_ADDR, 32'(rfmsc_pkg::FMT_NRZ));
            if (i == 1) wr(rfmsc_pkg::RADIO_DATA_ADDR, 32'h0F);
        end
        final_report();
    end
endmodule : testbench
